// ### lpg_power_gate.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpg_params.svh"

module lpg_power_gate (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire lpg_pkg::lpg_req_t     mode_req,
    input  wire logic                  irq_pending,
    input  wire logic                  irq_enable,
    input  wire logic                  reset_pin_n,
    input  wire lpg_pkg::lpg_link_cfg_t link_cfg,
    input  wire lpg_pkg::lpg_pin_t     port4_drive,
    output var  lpg_pkg::lpg_mode_t    mode,
    output var  lpg_pkg::lpg_ctrl_t    ctrl,
    output var  lpg_pkg::lpg_pin_t     port4
);
    import lpg_pkg::*;

    lpg_state_t st;
    lpg_state_t next_st;
    logic       mc_tick;
    logic       wake;
    logic       low_power;
    logic [11:0] rate_max;

    // Power-on contents: block awake, port four released to its pull-ups
    localparam lpg_state_t LPG_RST_ST = '{
        mode:    LPG_ACTIVE,
        div:     4'h0,
        rst_cnt: 2'h0,
        ctrl:    '{gsc_run:     1'b1,
                   dma_run:     1'b1,
                   core_run:    1'b1,
                   half_duplex: 1'b0,
                   rate_ok:     1'b0,
                   reset_hit:   1'b0},
        port4:   '{out: 1'b1, oe: 1'b0}
    };

    always_comb
    begin
        next_st   = st;
        mc_tick   = (st.div == `LPG_CLKS_PER_MCYCLE - 4'h1);
        wake      = irq_pending && irq_enable;
        next_st.div = mc_tick ? 4'h0 : st.div + 4'h1;
        next_st.ctrl.reset_hit = 1'b0;
        // Count machine cycles of a low reset pin
        if (reset_pin_n)
        begin
            next_st.rst_cnt = 2'h0;
        end
        else if (mc_tick && st.rst_cnt != `LPG_RST_MCYCLES)
        begin
            next_st.rst_cnt = st.rst_cnt + 2'h1;
        end
        unique case (st.mode)
            LPG_ACTIVE:
            begin
                if (mode_req.pdown_req)
                begin
                    next_st.mode = LPG_PDOWN;
                end
                else if (mode_req.idle_req)
                begin
                    next_st.mode = LPG_IDLE;
                end
            end
            LPG_IDLE:
            begin
                if (wake)
                begin
                    next_st.mode = LPG_ACTIVE;
                end
            end
            LPG_PDOWN:
            begin
                next_st.mode = LPG_PDOWN;
            end
        endcase
        if (st.rst_cnt == `LPG_RST_MCYCLES - 2'h1 && mc_tick && !reset_pin_n)
        begin
            next_st.mode = LPG_ACTIVE;
            next_st.ctrl.reset_hit = 1'b1;
        end
        low_power = (next_st.mode != LPG_ACTIVE);
        next_st.ctrl.core_run = !low_power;
        next_st.ctrl.dma_run  = !low_power;
        next_st.ctrl.gsc_run  = (next_st.mode == LPG_ACTIVE)
                             || (next_st.mode == LPG_IDLE && irq_enable);
        rate_max = link_cfg.ext_clk ? `LPG_MAX_KBPS_EXTCLK : `LPG_MAX_KBPS_RECOVER;
        next_st.ctrl.rate_ok = (link_cfg.rate_kbps <= rate_max);
        next_st.ctrl.half_duplex = link_cfg.manchester || link_cfg.half_duplex_req;
        if (low_power)
        begin
            next_st.port4.out = 1'b1;
            next_st.port4.oe  = 1'b0;
        end
        else
        begin
            next_st.port4 = port4_drive;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st <= LPG_RST_ST;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign mode  = st.mode;
    assign ctrl  = st.ctrl;
    assign port4 = st.port4;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_pdown_stays: assert property (
        st.mode == LPG_PDOWN && !next_st.ctrl.reset_hit |=> st.mode == LPG_PDOWN)
        else $error("power down left without reset");
    a_pdown_gsc_off: assert property (
        st.mode == LPG_PDOWN |-> !st.ctrl.gsc_run)
        else $error("serial channel runs in power down");
    a_idle_gsc_on: assert property (
        st.mode == LPG_IDLE && $past(irq_enable)
        |-> st.ctrl.gsc_run)
        else $error("serial channel stopped in idle with interrupts on");
    a_dma_halt: assert property (
        st.mode != LPG_ACTIVE |-> !st.ctrl.dma_run)
        else $error("dma runs in low power");
    a_idle_wake: assert property (
        st.mode == LPG_IDLE && irq_pending && irq_enable && reset_pin_n
        |=> st.mode == LPG_ACTIVE ##1 (st.mode == LPG_ACTIVE || $past(mode_req) != 2'b00))
        else $error("wake from idle failed or re-entered idle alone");
    a_port4_float: assert property (
        st.mode != LPG_ACTIVE |-> st.port4.out && !st.port4.oe)
        else $error("port four driven in low power");
    a_manch_half: assert property (
        link_cfg.manchester |=> st.ctrl.half_duplex)
        else $error("manchester without half duplex");
    a_rate_limit: assert property (
        link_cfg.rate_kbps > `LPG_MAX_KBPS_EXTCLK |=> !st.ctrl.rate_ok)
        else $error("rate above limit accepted");
    a_rst_count: assert property (
        st.ctrl.reset_hit |-> $past(reset_pin_n, 1) == 1'b0 && st.rst_cnt == `LPG_RST_MCYCLES)
        else $error("reset recognised too early");
    a_req_enter: assert property (
        st.mode == LPG_ACTIVE && mode_req.pdown_req && reset_pin_n |=> st.mode == LPG_PDOWN)
        else $error("power down request ignored");

    c_idle_wake: cover property (st.mode == LPG_IDLE ##1 st.mode == LPG_ACTIVE);
    c_pdown_reset: cover property (st.mode == LPG_PDOWN ##1 st.ctrl.reset_hit);
    c_idle_noirq: cover property (st.mode == LPG_IDLE && !st.ctrl.gsc_run);
    c_pdown_enter: cover property (st.mode == LPG_ACTIVE ##1 st.mode == LPG_PDOWN);
    c_rate_reject: cover property (!st.ctrl.rate_ok ##1 st.ctrl.rate_ok);

    // Link limits and duplex selection
    a_rate_recover: assert property (
        !link_cfg.ext_clk && link_cfg.rate_kbps > `LPG_MAX_KBPS_RECOVER
        |=> !st.ctrl.rate_ok)
        else $error("recovered-clock rate above limit accepted");
    a_rate_rec_ok: assert property (
        !link_cfg.ext_clk && link_cfg.rate_kbps <= `LPG_MAX_KBPS_RECOVER
        |=> st.ctrl.rate_ok)
        else $error("recovered-clock rate within limit refused");
    a_rate_ext_ok: assert property (
        link_cfg.ext_clk && link_cfg.rate_kbps <= `LPG_MAX_KBPS_EXTCLK
        |=> st.ctrl.rate_ok)
        else $error("external-clock rate within limit refused");
    a_half_req: assert property (
        link_cfg.half_duplex_req |=> st.ctrl.half_duplex)
        else $error("half duplex request ignored");
    a_half_free: assert property (
        !link_cfg.manchester && !link_cfg.half_duplex_req |=> !st.ctrl.half_duplex)
        else $error("half duplex forced without cause");

    // Mode control
    a_active_run: assert property (
        st.mode == LPG_ACTIVE |-> st.ctrl.gsc_run && st.ctrl.dma_run && st.ctrl.core_run)
        else $error("unit stopped while active");
    a_core_stop: assert property (
        st.mode != LPG_ACTIVE |-> !st.ctrl.core_run)
        else $error("core runs in low power");
    a_idle_enter: assert property (
        st.mode == LPG_ACTIVE && mode_req.idle_req && !mode_req.pdown_req && reset_pin_n
        |=> st.mode == LPG_IDLE)
        else $error("idle request ignored");
    a_idle_stay: assert property (
        st.mode == LPG_IDLE && !(irq_pending && irq_enable) && reset_pin_n
        |=> st.mode == LPG_IDLE)
        else $error("idle left without interrupt");
    a_pdown_irq: assert property (
        st.mode == LPG_PDOWN && irq_pending && irq_enable && reset_pin_n
        |=> st.mode == LPG_PDOWN)
        else $error("interrupt left power down");
    a_port4_pass: assert property (
        st.mode == LPG_ACTIVE && !$past(rst) |-> st.port4 == $past(port4_drive))
        else $error("port four not driven while active");

    // Reset pin recognition
    a_div_range: assert property (
        st.div <= `LPG_CLKS_PER_MCYCLE - 4'h1)
        else $error("machine cycle divider out of range");
    a_cnt_clear: assert property (
        reset_pin_n |=> st.rst_cnt == 2'h0)
        else $error("reset count kept with pin high");
    a_hit_pulse: assert property (
        st.ctrl.reset_hit |=> !st.ctrl.reset_hit)
        else $error("reset recognition longer than one cycle");
    a_hit_active: assert property (
        st.ctrl.reset_hit |-> st.mode == LPG_ACTIVE)
        else $error("reset recognised without leaving low power");
endmodule

`default_nettype wire

// ### lpg_params.svh
`ifndef LPG_PARAMS_SVH
`define LPG_PARAMS_SVH
`define LPG_CLKS_PER_MCYCLE   4'hC
`define LPG_RST_MCYCLES       2'h3
`define LPG_MAX_KBPS_RECOVER  12'h7D0
`define LPG_MAX_KBPS_EXTCLK   12'h960
`endif

// ### lpg_pkg.sv
package lpg_pkg;
    typedef enum logic [1:0] {LPG_ACTIVE, LPG_IDLE, LPG_PDOWN} lpg_mode_t;

    typedef struct packed {
        logic idle_req;
        logic pdown_req;
    } lpg_req_t;

    typedef struct packed {
        logic [11:0] rate_kbps;
        logic        ext_clk;
        logic        manchester;
        logic        half_duplex_req;
    } lpg_link_cfg_t;

    typedef struct packed {
        logic gsc_run;
        logic dma_run;
        logic core_run;
        logic half_duplex;
        logic rate_ok;
        logic reset_hit;
    } lpg_ctrl_t;

    typedef struct packed {
        logic out;
        logic oe;
    } lpg_pin_t;

    typedef struct packed {
        lpg_mode_t   mode;
        logic [3:0]  div;
        logic [1:0]  rst_cnt;
        lpg_ctrl_t   ctrl;
        lpg_pin_t    port4;
    } lpg_state_t;
endpackage

// ### lpg_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module lpg_core_model (
    input  wire logic               clk_sys,
    input  wire logic               fire,
    input  wire lpg_pkg::lpg_mode_t mode,
    output var  logic               irq_pending,
    output wire lpg_pkg::lpg_pin_t  port4_drive
);
    import lpg_pkg::*;
    initial irq_pending = 1'b0;
    assign port4_drive = '{1'b0, 1'b1};
    // Request held until the core runs again
    always @(posedge clk_sys)
    begin
        if (fire)
            irq_pending <= 1'b1;
        else if (mode == LPG_ACTIVE)
            irq_pending <= 1'b0;
    end
endmodule
`default_nettype wire

// ### lpg_power_gate_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define LPG_CHK(n, e, g) begin checked++; if ((e) !== (g)) begin mismatches++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module lpg_power_gate_tb;
    import lpg_pkg::*;
    logic          clk_sys = 0, rst = 1, irq_enable = 1, reset_pin_n = 1, fire = 0;
    logic          irq_pending;
    lpg_req_t      mode_req = '0;
    lpg_link_cfg_t link_cfg = '{12'h3E8, 1'b0, 1'b0, 1'b0};
    lpg_pin_t      port4_drive, port4;
    lpg_mode_t     mode;
    lpg_ctrl_t     ctrl;
    logic [9:0]    q[$], e;
    logic [1:0]    lk = 2'b01;
    int            mismatches = 0, checked = 0, cycles = 0, n;
    integer        seed = 32'hcb87acc5;
    always #2 clk_sys = ~clk_sys;
    lpg_power_gate DUT (.clk_sys(clk_sys), .rst(rst), .mode_req(mode_req),
        .irq_pending(irq_pending), .irq_enable(irq_enable), .reset_pin_n(reset_pin_n),
        .link_cfg(link_cfg), .port4_drive(port4_drive), .mode(mode), .ctrl(ctrl),
        .port4(port4));
    lpg_core_model core (.clk_sys(clk_sys), .fire(fire), .mode(mode),
        .irq_pending(irq_pending), .port4_drive(port4_drive));
    task automatic complete_run();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic want(lpg_mode_t m, logic g, logic d, logic [1:0] p);
        q.push_back({m, g, d, m == LPG_ACTIVE, lk, 1'b0, p});
    endtask
    task automatic step(lpg_req_t r);
        @(negedge clk_sys) mode_req = r;
        @(negedge clk_sys) mode_req = '0;
    endtask
    task automatic pulse_irq();
        @(negedge clk_sys) fire = 1;
        @(negedge clk_sys) fire = 0;
        repeat (4) @(negedge clk_sys);
    endtask
    always @(negedge clk_sys)
        while (q.size() > 0)
        begin
            e = q.pop_front();
            `LPG_CHK("state", e, {mode, ctrl, port4})
        end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            mismatches++;
            complete_run();
        end
    end
    initial
    begin
        repeat (6) @(negedge clk_sys);
        rst = 0;
        repeat (3) @(negedge clk_sys);
        want(LPG_ACTIVE, 1, 1, 2'b01);
        step('{1'b1, 1'b0}); want(LPG_IDLE, 1, 0, 2'b10);
        step('{1'b0, 1'b1}); want(LPG_IDLE, 1, 0, 2'b10);
        pulse_irq(); want(LPG_ACTIVE, 1, 1, 2'b01);
        $display("idle wake done");
        irq_enable = 0;
        step('{1'b1, 1'b0}); want(LPG_IDLE, 0, 0, 2'b10);
        pulse_irq(); want(LPG_IDLE, 0, 0, 2'b10);
        @(negedge clk_sys) irq_enable = 1;
        @(negedge clk_sys) want(LPG_ACTIVE, 1, 1, 2'b01);
        $display("masked wake done");
        step('{1'b1, 1'b1}); want(LPG_PDOWN, 0, 0, 2'b10);
        pulse_irq(); want(LPG_PDOWN, 0, 0, 2'b10);
        step('{1'b1, 1'b0}); want(LPG_PDOWN, 0, 0, 2'b10);
        @(negedge clk_sys) reset_pin_n = 0;
        n = 0;
        while (ctrl.reset_hit !== 1'b1 && n < 60)
        begin
            @(negedge clk_sys);
            n++;
        end
        `LPG_CHK("pin cycles", 1'b1, n >= 24 && n <= 37)
        @(negedge clk_sys) reset_pin_n = 1;
        `LPG_CHK("hit pulse", 1'b0, ctrl.reset_hit)
        @(negedge clk_sys) want(LPG_ACTIVE, 1, 1, 2'b01);
        $display("power down done");
        for (int i = 0; i < 12; i++)
        begin
            @(negedge clk_sys);
            link_cfg.ext_clk = i[0];
            link_cfg.manchester = i[1];
            link_cfg.half_duplex_req = i[2];
            link_cfg.rate_kbps = i < 4 ? (i[0] ? 12'h960 : 12'h7D0) + i[1] : 12'($random(seed));
            lk = {i[1] | i[2], link_cfg.rate_kbps <= (i[0] ? 12'h960 : 12'h7D0)};
            @(negedge clk_sys) want(LPG_ACTIVE, 1, 1, 2'b01);
        end
        repeat (2) @(negedge clk_sys);
        $display("link config done");
        complete_run();
    end
endmodule
`default_nettype wire
